// File: jmm_pkg.sv
package jmm_pkg;

  // ***********************************
  // word and instruction fields
  // ***********************************
  localparam int WORD_W   = 16;
  localparam int MARK_BIT = 15;
  localparam int GRP_HI   = 14;
  localparam int GRP_LO   = 13;
  localparam int OP_HI    = 12;
  localparam int OP_LO    = 11;
  localparam int IND_BIT  = 10;
  localparam int X_HI     = 9;
  localparam int X_LO     = 8;
  localparam int FN_HI    = 10;
  localparam int FN_LO    = 8;
  localparam int D_HI     = 7;

  typedef logic [WORD_W-1:0] word_type;

  localparam logic [1:0] X_PAGE0 = 2'h0;
  localparam logic [1:0] X_REL   = 2'h1;
  localparam logic [1:0] X_AC2   = 2'h2;
  localparam logic [1:0] X_AC3   = 2'h3;

  localparam logic [1:0] GRP_JUMP_MOD = 2'h0;
  localparam logic [1:0] GRP_LOAD     = 2'h1;
  localparam logic [1:0] GRP_STORE    = 2'h2;

  localparam logic [1:0] OP_JUMP = 2'h0;
  localparam logic [1:0] OP_CALL = 2'h1;
  localparam logic [1:0] OP_INC  = 2'h2;
  localparam logic [1:0] OP_DEC  = 2'h3;

  localparam word_type WORD_ONE  = 16'h0001;
  localparam word_type WORD_ZERO = 16'h0000;
  localparam word_type WORD_TWO  = 16'h0002;
  localparam word_type CHAIN_MASK = 16'h7fff;

  // ***********************************
  // carriers and states
  // ***********************************
  typedef struct packed {
    logic     valid;
    logic     write;
    word_type addr;
    word_type wdata;
  } mem_req_type;

  typedef struct packed {
    logic       done;
    word_type   next_pc;
    logic       ac3_we;
    word_type   ac3_data;
    logic       is_alu;
    logic [2:0] alu_func;
    logic       is_load;
    logic       is_store;
    logic [1:0] ac_sel;
    word_type   ea;
  } result_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_EVAL  = 3'h1,
    ST_INDIR = 3'h3,
    ST_READ  = 3'h2,
    ST_WRITE = 3'h6,
    ST_FIN   = 3'h4
  } state_type;

endpackage

// File: ea_former.sv
`timescale 1ns/1ps
module ea_former (
  input  wire logic [1:0]       mode_in,  // index field
  input  wire logic [7:0]       disp_in,  // displacement field
  input  wire jmm_pkg::word_type pc_in,   // program counter
  input  wire jmm_pkg::word_type ac2_in,  // accumulator 2
  input  wire jmm_pkg::word_type ac3_in,  // accumulator 3
  output jmm_pkg::word_type      ea_out    // effective address
);
  import jmm_pkg::*;

  wire word_type disp_zext = {8'h00, disp_in};
  wire word_type disp_sext = {{8{disp_in[7]}}, disp_in};
  wire word_type base_w    = (mode_in == X_REL) ? pc_in :
                             (mode_in == X_AC2) ? ac2_in : ac3_in;

  // page zero is the bare field
  assign ea_out = (mode_in == X_PAGE0) ? disp_zext : base_w + disp_sext;
endmodule

// File: jump_modify_memory_exec.sv
// What this block does
// - opcode bits 1-2 zero selects jump/modify group by bits 3-4
// - jump loads effective address into program counter
// - call: form address, save pc plus one in ac3, then jump
// - increment memory word, write back, skip next if zero
// - decrement memory word, write back, skip next if zero
// - index 00: displacement alone is the address
// - index 01: program counter is the base
// - accumulator field 0-3 selects accumulators 0-3
// - bit 0 set marks alu instruction, function in bits 5-7
// - index 10/11: ac2 or ac3 plus signed displacement
// - relative displacement is signed, -128 to +127
`timescale 1ns/1ps
module jump_modify_memory_exec (
  input  wire logic                clock_in,     // 100 MHz clock
  input  wire logic                rst_in,       // sync reset, active high
  input  wire logic                start_in,     // instruction ready to execute
  input  wire jmm_pkg::word_type   instr_in,     // instruction word
  input  wire jmm_pkg::word_type   pc_in,        // current program counter
  input  wire jmm_pkg::word_type   ac2_in,       // accumulator 2
  input  wire jmm_pkg::word_type   ac3_in,       // accumulator 3
  output logic                     busy_out,     // executing
  output jmm_pkg::mem_req_type     mem_out,      // memory request
  input  wire logic                mem_ready_in, // memory accepts / answers
  input  wire jmm_pkg::word_type   mem_rdata_in, // memory read data
  output jmm_pkg::result_type      result_out    // outcome, done is a pulse
);
  import jmm_pkg::*;

  // ***********************************
  // state
  // ***********************************
  state_type  state_q, state_d;
  word_type   instr_q, pc_q, ac2_q, ac3_q, ea_q, data_q;
  result_type result_q;

  // ***********************************
  // decode
  // ***********************************
  // alu marker and function
  wire logic       is_alu_w   = instr_q[MARK_BIT];
  wire logic [2:0] alu_fn_w   = instr_q[FN_HI:FN_LO];
  wire logic [1:0] grp_w      = instr_q[GRP_HI:GRP_LO];
  wire logic [1:0] op_w       = instr_q[OP_HI:OP_LO];
  wire logic       jm_grp_w   = !is_alu_w && grp_w == GRP_JUMP_MOD;
  wire logic       is_jump_w  = jm_grp_w && op_w == OP_JUMP;
  wire logic       is_call_w  = jm_grp_w && op_w == OP_CALL;
  wire logic       is_inc_w   = jm_grp_w && op_w == OP_INC;
  wire logic       is_dec_w   = jm_grp_w && op_w == OP_DEC;
  wire logic       is_mod_w   = is_inc_w || is_dec_w;
  wire logic       is_load_w  = !is_alu_w && grp_w == GRP_LOAD;
  wire logic       is_store_w = !is_alu_w && grp_w == GRP_STORE;
  wire logic       ind_w      = !is_alu_w && instr_q[IND_BIT];
  wire logic [1:0] xmode_w    = instr_q[X_HI:X_LO];
  wire word_type   ea_w;

  ea_former u_ea (
    .mode_in (xmode_w),
    .disp_in (instr_q[D_HI:0]),
    .pc_in   (pc_q),
    .ac2_in  (ac2_q),
    .ac3_in  (ac3_q),
    .ea_out  (ea_w)
  );

  wire word_type mod_val_w  = is_inc_w ? mem_rdata_in + WORD_ONE
                                       : mem_rdata_in - WORD_ONE;
  wire logic     skip_w     = is_mod_w && data_q == WORD_ZERO;
  wire word_type pc_next1_w = pc_q + WORD_ONE;
  wire word_type pc_next2_w = pc_q + WORD_TWO;
  // jumps take the address, skip by two
  wire word_type next_pc_w  = (is_jump_w || is_call_w) ? ea_q :
                              skip_w ? pc_next2_w : pc_next1_w;
  // indirect chain: it ends on a word with the top bit clear
  wire logic     chain_w    = mem_rdata_in[MARK_BIT];
  wire logic     in_mem_w   = state_q == ST_INDIR || state_q == ST_READ ||
                              state_q == ST_WRITE;

  assign busy_out      = state_q != ST_IDLE;
  // one driver for the whole request word
  wire logic     wr_phase_w = state_q == ST_WRITE;
  assign mem_out       = '{valid: in_mem_w, write: wr_phase_w, addr: ea_q, wdata: data_q};
  assign result_out    = result_q;

  // ***********************************
  // sequencer
  // ***********************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:  if (start_in) state_d = ST_EVAL;
      ST_EVAL:  state_d = ind_w ? ST_INDIR : is_mod_w ? ST_READ : ST_FIN;
      ST_INDIR: if (mem_ready_in && !chain_w) state_d = is_mod_w ? ST_READ : ST_FIN;
      ST_READ:  if (mem_ready_in) state_d = ST_WRITE;
      ST_WRITE: if (mem_ready_in) state_d = ST_FIN;
      ST_FIN:   state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) state_q <= ST_IDLE;
    else        state_q <= state_d;
  end

  // operands are frozen at start so the caller may move on
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      instr_q <= WORD_ZERO;
      pc_q    <= WORD_ZERO;
      ac2_q   <= WORD_ZERO;
      ac3_q   <= WORD_ZERO;
    end else if (state_q == ST_IDLE && start_in) begin
      instr_q <= instr_in;
      pc_q    <= pc_in;
      ac2_q   <= ac2_in;
      ac3_q   <= ac3_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ea_q <= WORD_ZERO;
    end else if (state_q == ST_EVAL) begin
      ea_q <= ea_w;
    end else if (state_q == ST_INDIR && mem_ready_in) begin
      ea_q <= chain_w ? (mem_rdata_in & CHAIN_MASK) : mem_rdata_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in)                              data_q <= WORD_ZERO;
    else if (state_q == ST_READ && mem_ready_in) data_q <= mod_val_w;
  end

  // ***********************************
  // result
  // ***********************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      result_q <= '0;
    end else if (state_q == ST_FIN) begin
      result_q.done     <= 1'b1;
      result_q.next_pc  <= next_pc_w;
      // return link is pc plus one
      result_q.ac3_we   <= is_call_w;
      result_q.ac3_data <= pc_next1_w;
      result_q.is_alu   <= is_alu_w;
      result_q.alu_func <= alu_fn_w;
      result_q.is_load  <= is_load_w;
      result_q.is_store <= is_store_w;
      result_q.ac_sel   <= op_w;
      result_q.ea       <= ea_q;
    end else begin
      result_q.done     <= 1'b0;
    end
  end

  // ***********************************
  // checks
  // ***********************************
  wire word_type rel_off_w = ea_w - pc_q;

  jump_target_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_FIN && is_jump_w |=> result_q.done && result_q.next_pc == $past(ea_q)
  ) else $error("jump did not load address");

  call_link_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_FIN && is_call_w |=> result_q.ac3_we &&
      result_q.ac3_data == $past(pc_q) + WORD_ONE && result_q.next_pc == $past(ea_q)
  ) else $error("call link or target wrong");

  inc_write_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_READ && mem_ready_in && is_inc_w |=>
      mem_out.valid && mem_out.write && mem_out.wdata == $past(mem_rdata_in) + WORD_ONE
  ) else $error("increment write-back wrong");

  dec_write_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_READ && mem_ready_in && is_dec_w |=>
      mem_out.write && mem_out.wdata == $past(mem_rdata_in) - WORD_ONE
  ) else $error("decrement write-back wrong");

  skip_zero_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_FIN && is_mod_w |=> result_q.next_pc ==
      $past(pc_q) + ($past(data_q) == WORD_ZERO ? WORD_TWO : WORD_ONE)
  ) else $error("skip decision wrong");

  wrap_zero_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_READ && mem_ready_in && is_inc_w && mem_rdata_in == 16'hffff
      |=> data_q == WORD_ZERO
  ) else $error("increment did not wrap");

  ind_fetch_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_EVAL && ind_w |=> mem_out.valid && !mem_out.write && mem_out.addr == $past(ea_w)
  ) else $error("indirect fetch missing");

  page_zero_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_EVAL && xmode_w == X_PAGE0 |-> ea_w == {8'h00, instr_q[D_HI:0]}
  ) else $error("page zero address wrong");

  rel_span_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_EVAL && xmode_w == X_REL |->
      (rel_off_w <= 16'h007f || rel_off_w >= 16'hff80)
  ) else $error("relative offset out of span");

  base_reg_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_EVAL && xmode_w == X_AC3 |->
      ea_w == ac3_q + {{8{instr_q[D_HI]}}, instr_q[D_HI:0]}
  ) else $error("base register address wrong");

  alu_mark_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_FIN && is_alu_w |=> result_q.is_alu && !result_q.ac3_we &&
      result_q.alu_func == $past(instr_q[FN_HI:FN_LO])
  ) else $error("alu decode wrong");

  no_mod_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_EVAL && grp_w != GRP_JUMP_MOD && !ind_w |=> state_q == ST_FIN
  ) else $error("non-group instruction touched memory");
endmodule

// File: mem_model.sv
`timescale 1ns/1ps
module mem_model
  import jmm_pkg::*;
(
  input  wire logic                 clock_in,  // clock
  input  wire logic                 rst_in,    // sync reset, active high
  input  wire logic [3:0]           wait_in,   // idle cycles before each answer
  input  wire jmm_pkg::mem_req_type mem_in,    // request from the block
  output logic                      ready_out, // accept write / read data valid
  output jmm_pkg::word_type         rdata_out  // read data
);
  word_type   words [0:65535];
  logic [3:0] cnt_q;
  word_type   last_q;

  // slow answers: hold off until the wait count runs out
  assign ready_out = mem_in.valid && (cnt_q == wait_in);
  // outside an answer show the inverse of last_q, the bus value at the last answer, so after a write it is the last word read
  assign rdata_out = (ready_out && !mem_in.write) ? words[mem_in.addr] : ~last_q;

  // plain always: the bench preloads words from outside
  always @(posedge clock_in) begin
    if (rst_in) begin
      cnt_q  <= 4'h0;
      last_q <= 16'h0000;
    end else if (ready_out) begin
      cnt_q  <= 4'h0;
      last_q <= rdata_out;
      if (mem_in.write) begin
        words[mem_in.addr] <= mem_in.wdata;
      end
    end else if (mem_in.valid) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// File: jump_modify_memory_exec_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module jump_modify_memory_exec_test;
  import jmm_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_in   = 1'b1;
  logic        start_in = 1'b0;
  logic        mem_ready_in;
  logic        busy_out;
  logic [3:0]  wait_cycles = 4'h0;
  word_type    instr_in, pc_in, ac2_in, ac3_in, mem_rdata_in;
  mem_req_type mem_out;
  result_type  result_out;
  int          bad_count    = 0;
  int          total_checks = 0;

  always #5 clock_in = ~clock_in;

  jump_modify_memory_exec u_jump_modify_memory_exec (
    .clock_in(clock_in), .rst_in(rst_in), .start_in(start_in), .instr_in(instr_in),
    .pc_in(pc_in), .ac2_in(ac2_in), .ac3_in(ac3_in), .busy_out(busy_out),
    .mem_out(mem_out), .mem_ready_in(mem_ready_in), .mem_rdata_in(mem_rdata_in),
    .result_out(result_out));
  mem_model u_mem_model (
    .clock_in(clock_in), .rst_in(rst_in), .wait_in(wait_cycles), .mem_in(mem_out),
    .ready_out(mem_ready_in), .rdata_out(mem_rdata_in));

  // ***********************************
  // helpers
  // ***********************************
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic word_type mk(input logic [1:0] g, input logic [1:0] op,
                                  input logic ind, input logic [1:0] x, input logic [7:0] d);
    return {1'b0, g, op, ind, x, d};
  endfunction

  // noise: start stays high one cycle while busy, must be ignored
  task run(input word_type ins, input word_type pc, input logic noise);
    int n;
    @(posedge clock_in);
    #1 start_in = 1'b1;
    instr_in = ins;
    pc_in    = pc;
    @(posedge clock_in);
    #1 start_in = noise;
    instr_in = 16'hffff;
    `CHK(busy_out, 1'b1)
    @(posedge clock_in);
    #1 start_in = 1'b0;
    for (n = 0; n < 40 && result_out.done !== 1'b1; n++) begin
      @(posedge clock_in);
      #1;
    end
    `CHK(result_out.done, 1'b1)
    `CHK(busy_out, 1'b0)
    `CHK(mem_out.valid, 1'b0)
  endtask

  task mod_chk(input logic [1:0] op, input word_type a, input word_type m,
               input word_type exp, input logic [3:0] w);
    wait_cycles = w;
    u_mem_model.words[a] = m;
    run(mk(GRP_JUMP_MOD, op, 1'b0, X_PAGE0, a[7:0]), 16'h0200, 1'b1);
    `CHK(u_mem_model.words[a], exp)
    `CHK(result_out.next_pc, (exp == 16'h0000) ? 16'h0202 : 16'h0201)
  endtask

  // ***********************************
  // scenarios
  // ***********************************
  task t_jump;
    run(mk(GRP_JUMP_MOD, OP_JUMP, 1'b0, X_PAGE0, 8'h85), 16'h4000, 1'b0);
    `CHK(result_out.next_pc, 16'h0085)
    `CHK(result_out.ac3_we, 1'b0)
    run(mk(GRP_JUMP_MOD, OP_JUMP, 1'b0, X_REL, 8'h80), 16'h1000, 1'b0);
    `CHK(result_out.next_pc, 16'h0f80)
    run(mk(GRP_JUMP_MOD, OP_JUMP, 1'b0, X_REL, 8'h7f), 16'h1000, 1'b0);
    `CHK(result_out.next_pc, 16'h107f)
  endtask

  task t_call;
    ac2_in = 16'h3000;
    ac3_in = 16'h2000;
    run(mk(GRP_JUMP_MOD, OP_CALL, 1'b0, X_AC3, 8'hfe), 16'h0500, 1'b1);
    `CHK(result_out.next_pc, 16'h1ffe)
    `CHK(result_out.ac3_we, 1'b1)
    `CHK(result_out.ac3_data, 16'h0501)
    run(mk(GRP_JUMP_MOD, OP_JUMP, 1'b0, X_AC2, 8'h10), 16'h0500, 1'b0);
    `CHK(result_out.next_pc, 16'h3010)
  endtask

  // wrap at all-ones, plus a slow memory
  task t_inc;
    mod_chk(OP_INC, 16'h0040, 16'hffff, 16'h0000, 4'h0);
    mod_chk(OP_INC, 16'h0041, 16'h0005, 16'h0006, 4'h2);
  endtask

  task t_dec;
    mod_chk(OP_DEC, 16'h0042, 16'h0001, 16'h0000, 4'h3);
    mod_chk(OP_DEC, 16'h0043, 16'h0000, 16'hffff, 4'h1);
  endtask

  task t_ind;
    wait_cycles = 4'h1;
    u_mem_model.words[16'h0050] = 16'h8060;
    u_mem_model.words[16'h0060] = 16'h0345;
    run(mk(GRP_JUMP_MOD, OP_JUMP, 1'b1, X_PAGE0, 8'h50), 16'h0100, 1'b0);
    `CHK(result_out.next_pc, 16'h0345)
  endtask

  task t_alu;
    for (int f = 0; f < 8; f++) begin
      run({1'b1, 4'h0, f[2:0], 8'h00}, 16'h0300, 1'b0);
      `CHK(result_out.is_alu, 1'b1)
      `CHK(result_out.alu_func, f[2:0])
    end
  endtask

  task t_ldst;
    for (int a = 0; a < 4; a++) begin
      run(mk(GRP_LOAD, a[1:0], 1'b0, X_PAGE0, 8'h33), 16'h0300, 1'b0);
      `CHK(result_out.is_load, 1'b1)
      `CHK(result_out.ac_sel, a[1:0])
      `CHK(result_out.ea, 16'h0033)
    end
    run(mk(GRP_STORE, 2'h3, 1'b0, X_PAGE0, 8'h34), 16'h0300, 1'b0);
    `CHK(result_out.is_store, 1'b1)
    `CHK(result_out.ac_sel, 2'h3)
  endtask

  // reset lands mid read: bus and busy drop at once, the word is untouched
  task t_reset;
    wait_cycles = 4'h5;
    u_mem_model.words[16'h0044] = 16'h0010;
    @(posedge clock_in);
    #1 start_in = 1'b1;
    instr_in = mk(GRP_JUMP_MOD, OP_INC, 1'b0, X_PAGE0, 8'h44);
    pc_in    = 16'h0200;
    @(posedge clock_in);
    #1 start_in = 1'b0;
    @(posedge clock_in);
    @(posedge clock_in);
    #1;
    `CHK(mem_out.valid, 1'b1)
    `CHK(mem_out.addr, 16'h0044)
    rst_in = 1'b1;
    @(posedge clock_in);
    #1;
    `CHK(busy_out, 1'b0)
    `CHK(mem_out.valid, 1'b0)
    `CHK(result_out.done, 1'b0)
    `CHK(result_out.next_pc, 16'h0000)
    @(posedge clock_in);
    #1 rst_in = 1'b0;
    `CHK(u_mem_model.words[16'h0044], 16'h0010)
    wait_cycles = 4'h0;
    run(mk(GRP_JUMP_MOD, OP_JUMP, 1'b0, X_PAGE0, 8'h12), 16'h0700, 1'b0);
    `CHK(result_out.next_pc, 16'h0012)
  endtask

  // ***********************************
  // sequence and watchdog
  // ***********************************
  initial begin
    instr_in = 16'h0000;
    pc_in    = 16'h0000;
    ac2_in   = 16'h0000;
    ac3_in   = 16'h0000;
    repeat (4) @(posedge clock_in);
    #1 rst_in = 1'b0;
    t_jump;
    t_call;
    t_inc;
    t_dec;
    t_ind;
    t_alu;
    t_ldst;
    t_reset;
    end_sim;
  end

  // the whole run needs well under 5000 ns
  initial begin
    #20000;
    bad_count++;
    end_sim;
  end
endmodule
